// file: include/usb_cfg_regs_cfg.svh
// Command codes, field positions, reset values and timing of the configuration registers
`ifndef USB_CFG_REGS_CFG_SVH
`define USB_CFG_REGS_CFG_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_ADDR_WR     8'hB6
`define CMD_ADDR_RD     8'hB7
`define CMD_MODE_WR     8'hB8
`define CMD_MODE_RD     8'hB9
`define CMD_HW_WR       8'hBA
`define CMD_HW_RD       8'hBB

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADDR_EN_BIT     7
`define MODE_DMAWIDTH   7
`define MODE_SUSPEND    5
`define MODE_IRQ_EN     3
`define MODE_VERBOSE    2
`define MODE_PULLUP     0
`define HW_EXT_PULLUP   14
`define HW_SLOW_DIS     13
`define HW_CLK_ON       12
`define HW_DIV_HI       11
`define HW_DIV_LO       8

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define ADDR_RESET      8'h00
`define MODE_RESET      8'h00
`define MODE_KEEP_MASK  8'h8F
`define HW_RESET        16'h2340
`define DATA_ZERO       16'h0000
`define BYTE_ZERO       8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ          25000000
`define SUSP_DELAY_US   2000
`define SLOW_CLK_HZ     100000
`define SUSP_CYCLES     (`SUSP_DELAY_US * (`CLK_HZ / 1000000))
`define SLOW_HALF       (`CLK_HZ / (2 * `SLOW_CLK_HZ))

`endif

// file: include/usb_cfg_regs_pkg.sv
// Types shared by the configuration register set
package usb_cfg_regs_pkg;

  // ----------------------------------------
  // Command phase
  // ----------------------------------------
  typedef enum logic [2:0] {
    ph_idle,
    ph_wr_addr,
    ph_wr_mode,
    ph_wr_hw
  } cmd_phase_e;

  // ----------------------------------------
  // Whole module state
  // ----------------------------------------
  typedef struct packed {
    cmd_phase_e  phase;
    logic [7:0]  device_address_enable;
    logic [7:0]  controller_mode;
    logic [15:0] hardware_setup;
    logic [6:0]  active_addr;
    logic        active_en;
    logic        suspended;
    logic        susp_done;
    logic [15:0] susp_cnt;
    logic [3:0]  div_cnt;
    logic [3:0]  div_val;
    logic [6:0]  slow_cnt;
    logic        slow_level;
    logic        clock_output_pin;
    logic [15:0] rd_data;
    logic        irq;
  } cfg_state_s;

  // ----------------------------------------
  // Device event inputs
  // ----------------------------------------
  typedef struct packed {
    logic bulk_ack;
    logic iso_done;
    logic nak;
    logic error;
  } usb_events_s;

endpackage : usb_cfg_regs_pkg

// file: hw/usb_device_config_registers.sv
// Configuration register set of a full-speed device controller
// Functional notes
// - Address bit 7 enables the function
// - Low seven address bits give device address
// - Mode write B8, read B9, one word
// - Mode holds one byte, upper discarded
// - Mode bit 7 selects DMA width
// - Suspend after writing 1 then 0
// - Mode bit 3 gates all interrupts
// - Bit 2: NAK/error, else ACK/iso interrupts
// - Bit 0 pull-up, ignored if external
// - Mode resets zero; some bits survive bus reset
// - Setup write BA, read BB, one word
// - Setup register two bytes wide
// - Setup register unchanged by bus reset
// - External pull-up select disables internal pull-up
// - Output clock divided, changes glitch-free
// - Slow clock output 2 ms after suspend
`timescale 1ns/1ps
`include "usb_cfg_regs_cfg.svh"

module usb_device_config_registers #(
  parameter int SUSP_CYCLES = `SUSP_CYCLES
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Processor command bus
  input  wire logic                         bus_cmd_i,
  input  wire logic                         bus_wr_i,
  input  wire logic                         bus_rd_i,
  input  wire logic [15:0]                  bus_data_i,
  output      logic [15:0]                  bus_data_o,
  // USB side
  input  wire logic                         usb_bus_reset_i,
  input  wire logic                         address_commit_i,
  input  wire logic                         resume_i,
  input  wire usb_cfg_regs_pkg::usb_events_s events_i,
  // Controls
  output      logic                         function_enable_o,
  output      logic [6:0]                   assigned_usb_address_o,
  output      logic                         dma_width_select_o,
  output      logic                         suspended_o,
  output      logic                         irq_o,
  output      logic                         internal_pullup_connect_o,
  output      logic                         osc_stop_o,
  output      logic                         clock_output_pin_o
);

  localparam logic [15:0] SUSP_LAST = 16'(SUSP_CYCLES - 1);
  localparam logic [6:0]  SLOW_LAST = 7'(`SLOW_HALF - 1);

  usb_cfg_regs_pkg::cfg_state_s st;
  usb_cfg_regs_pkg::cfg_state_s next_st;

  // ----------------------------------------
  // Read data for a read command code
  // ----------------------------------------
  function automatic logic [15:0] read_value(input logic [7:0]                   code,
                                             input usb_cfg_regs_pkg::cfg_state_s s);
    unique case (code)
      `CMD_ADDR_RD: read_value = {`BYTE_ZERO, s.device_address_enable};
      `CMD_MODE_RD: read_value = {`BYTE_ZERO, s.controller_mode};
      `CMD_HW_RD:   read_value = s.hardware_setup;
      default:      read_value = s.rd_data;
    endcase
  endfunction : read_value

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic       mode_wr;
  logic       susp_trigger;
  logic [4:0] div_half;
  logic       irq_src;

  always_comb begin
    next_st = st;
    mode_wr = (st.phase == usb_cfg_regs_pkg::ph_wr_mode) && bus_wr_i;
    // Falling write of the suspend bit after a stored one
    susp_trigger = mode_wr && st.controller_mode[`MODE_SUSPEND] &&
                   !bus_data_i[`MODE_SUSPEND];

    // Command phase: one data word per command
    if (bus_cmd_i) begin
      unique case (bus_data_i[7:0])
        `CMD_ADDR_WR: next_st.phase = usb_cfg_regs_pkg::ph_wr_addr;
        `CMD_MODE_WR: next_st.phase = usb_cfg_regs_pkg::ph_wr_mode;
        `CMD_HW_WR:   next_st.phase = usb_cfg_regs_pkg::ph_wr_hw;
        default:      next_st.phase = usb_cfg_regs_pkg::ph_idle;
      endcase
      next_st.rd_data = read_value(bus_data_i[7:0], st);
    end else if (bus_wr_i) begin
      next_st.phase = usb_cfg_regs_pkg::ph_idle;
    end

    // Register writes
    if (!bus_cmd_i && bus_wr_i) begin
      unique case (st.phase)
        usb_cfg_regs_pkg::ph_wr_addr: next_st.device_address_enable = bus_data_i[7:0];
        usb_cfg_regs_pkg::ph_wr_mode: next_st.controller_mode = bus_data_i[7:0];
        usb_cfg_regs_pkg::ph_wr_hw:   next_st.hardware_setup = bus_data_i;
        usb_cfg_regs_pkg::ph_idle:    next_st.phase = usb_cfg_regs_pkg::ph_idle;
      endcase
    end

    // Bus reset clears the non-kept mode bits and the active address, and sets the function enable
    if (usb_bus_reset_i) begin
      next_st.controller_mode = next_st.controller_mode & `MODE_KEEP_MASK;
      next_st.active_addr = 7'h00;
      next_st.active_en = 1'b1;
    end else if (address_commit_i) begin
      next_st.active_addr = st.device_address_enable[6:0];
      next_st.active_en = st.device_address_enable[`ADDR_EN_BIT];
    end

    // Suspend entry and delay
    if (susp_trigger) begin
      next_st.suspended = 1'b1;
      next_st.susp_done = 1'b0;
      next_st.susp_cnt = 16'h0000;
    end else if (resume_i || usb_bus_reset_i) begin
      next_st.suspended = 1'b0;
      next_st.susp_done = 1'b0;
      next_st.susp_cnt = 16'h0000;
    end else if (st.suspended && !st.susp_done) begin
      if (st.susp_cnt == SUSP_LAST) begin
        next_st.susp_done = 1'b1;
      end else begin
        next_st.susp_cnt = st.susp_cnt + 16'h0001;
      end
    end

    // Output divider, new factor taken only at period end
    div_half = (5'(st.div_val) + 5'h02) >> 1;
    if (st.div_cnt == st.div_val) begin
      next_st.div_cnt = 4'h0;
      next_st.div_val = st.hardware_setup[`HW_DIV_HI:`HW_DIV_LO];
    end else begin
      next_st.div_cnt = st.div_cnt + 4'h1;
    end

    // Slow clock generator
    if (st.slow_cnt == SLOW_LAST) begin
      next_st.slow_cnt = 7'h00;
      next_st.slow_level = !st.slow_level;
    end else begin
      next_st.slow_cnt = st.slow_cnt + 7'h01;
    end

    // Clock output selection
    if (st.susp_done) begin
      next_st.clock_output_pin = !st.hardware_setup[`HW_SLOW_DIS] && st.slow_level;
    end else begin
      next_st.clock_output_pin = 5'(st.div_cnt) < div_half;
    end

    // Interrupt selection and gating
    if (st.controller_mode[`MODE_VERBOSE]) begin
      irq_src = events_i.nak || events_i.error;
    end else begin
      irq_src = events_i.bulk_ack || events_i.iso_done;
    end
    next_st.irq = st.controller_mode[`MODE_IRQ_EN] && irq_src;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.phase <= usb_cfg_regs_pkg::ph_idle;
      st.device_address_enable <= `ADDR_RESET;
      st.controller_mode <= `MODE_RESET;
      st.hardware_setup <= `HW_RESET;
      st.rd_data <= `DATA_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_data_o                = st.rd_data;
  assign function_enable_o         = st.active_en;
  assign assigned_usb_address_o    = st.active_addr;
  assign dma_width_select_o        = st.controller_mode[`MODE_DMAWIDTH];
  assign suspended_o               = st.suspended;
  assign irq_o                     = st.irq;
  assign internal_pullup_connect_o = st.controller_mode[`MODE_PULLUP] &&
                                     !st.hardware_setup[`HW_EXT_PULLUP];
  assign osc_stop_o                = st.susp_done && !st.hardware_setup[`HW_CLK_ON];
  assign clock_output_pin_o        = st.clock_output_pin;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_addr_store;
    @(posedge clk_i) disable iff (rst_i)
      (st.phase == usb_cfg_regs_pkg::ph_wr_addr && bus_wr_i && !bus_cmd_i)
      |=> (st.device_address_enable == $past(bus_data_i[7:0]));
  endproperty
  a_addr_store: assert property (p_addr_store) else $error("address write lost");

  property p_commit;
    @(posedge clk_i) disable iff (rst_i)
      (address_commit_i && !usb_bus_reset_i)
      |=> (function_enable_o == $past(st.device_address_enable[7]))
          && (assigned_usb_address_o == $past(st.device_address_enable[6:0]));
  endproperty
  a_commit: assert property (p_commit) else $error("address commit wrong");

  property p_one_word;
    @(posedge clk_i) disable iff (rst_i)
      (st.phase != usb_cfg_regs_pkg::ph_idle && bus_wr_i && !bus_cmd_i)
      |=> (st.phase == usb_cfg_regs_pkg::ph_idle);
  endproperty
  a_one_word: assert property (p_one_word) else $error("more than one word taken");

  property p_mode_byte;
    @(posedge clk_i) disable iff (rst_i)
      (mode_wr && !bus_cmd_i && !usb_bus_reset_i)
      |=> (st.controller_mode == $past(bus_data_i[7:0]));
  endproperty
  a_mode_byte: assert property (p_mode_byte) else $error("mode byte wrong");

  property p_mode_read;
    @(posedge clk_i) disable iff (rst_i)
      (bus_cmd_i && bus_data_i[7:0] == `CMD_MODE_RD)
      |=> (bus_data_o == {`BYTE_ZERO, $past(st.controller_mode)});
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

  property p_dma_width;
    @(posedge clk_i) disable iff (rst_i)
      (mode_wr && !bus_cmd_i) |=> (dma_width_select_o == $past(bus_data_i[`MODE_DMAWIDTH]));
  endproperty
  a_dma_width: assert property (p_dma_width) else $error("DMA width select wrong");

  property p_suspend;
    @(posedge clk_i) disable iff (rst_i)
      susp_trigger
      |=> suspended_o && !st.susp_done && (st.susp_cnt == 16'h0000);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not entered");

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i)
      !st.controller_mode[`MODE_IRQ_EN] |=> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

  property p_verbose;
    @(posedge clk_i) disable iff (rst_i)
      (st.controller_mode[`MODE_IRQ_EN] && st.controller_mode[`MODE_VERBOSE] && events_i.nak)
      |=> irq_o;
  endproperty
  a_verbose: assert property (p_verbose) else $error("NAK interrupt missing");

  property p_pullup;
    @(posedge clk_i) disable iff (rst_i)
      st.hardware_setup[`HW_EXT_PULLUP] |-> !internal_pullup_connect_o;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not ignored");

  property p_bus_reset_keep;
    @(posedge clk_i) disable iff (rst_i)
      (usb_bus_reset_i && !bus_wr_i)
      |=> ((st.controller_mode & ~`MODE_KEEP_MASK) == `BYTE_ZERO)
          && ((st.controller_mode & `MODE_KEEP_MASK)
              == ($past(st.controller_mode) & `MODE_KEEP_MASK))
          && $stable(st.hardware_setup);
  endproperty
  a_bus_reset_keep: assert property (p_bus_reset_keep) else $error("bus reset wrong");

  property p_div_glitch;
    @(posedge clk_i) disable iff (rst_i)
      (st.div_cnt != st.div_val) |=> $stable(st.div_val);
  endproperty
  a_div_glitch: assert property (p_div_glitch) else $error("divider changed mid period");

  property p_osc_stop;
    @(posedge clk_i) disable iff (rst_i)
      osc_stop_o |-> suspended_o && !st.hardware_setup[`HW_CLK_ON];
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator stopped early");

  property p_slow_off;
    @(posedge clk_i) disable iff (rst_i)
      (st.susp_done && st.hardware_setup[`HW_SLOW_DIS]) |=> !clock_output_pin_o;
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("slow clock not held low");

  c_suspend_done: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st.susp_done));
  c_irq:          cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_bus_reset:    cover property (@(posedge clk_i) disable iff (rst_i) usb_bus_reset_i);
  c_hw_write:     cover property (@(posedge clk_i) disable iff (rst_i)
                    st.phase == usb_cfg_regs_pkg::ph_wr_hw && bus_wr_i);

endmodule : usb_device_config_registers

// file: tb/proc_bus_model.sv
// Processor model on the parallel command bus of the register set
`timescale 1ns/1ps

module proc_bus_model (
  // Clock
  input  wire logic        clk_i,
  // Command bus
  output      logic        bus_cmd_o,
  output      logic        bus_wr_o,
  output      logic        bus_rd_o,
  output      logic [15:0] bus_data_o
);

  initial begin
    bus_cmd_o  = 1'b0;
    bus_wr_o   = 1'b0;
    bus_rd_o   = 1'b0;
    bus_data_o = 16'h0000;
  end

  // ----------------------------------------
  // Releases the strobes and scrambles the data lines
  // ----------------------------------------
  task automatic release_bus();
    bus_cmd_o  = 1'b0;
    bus_wr_o   = 1'b0;
    bus_rd_o   = 1'b0;
    bus_data_o = ~bus_data_o;
  endtask : release_bus

  // ----------------------------------------
  // One command code, then exactly one data word
  // ----------------------------------------
  task automatic write_word(input logic [7:0] code, input logic [15:0] word);
    @(negedge clk_i);
    bus_cmd_o  = 1'b1;
    bus_data_o = {8'h00, code};
    @(negedge clk_i);
    bus_cmd_o  = 1'b0;
    bus_wr_o   = 1'b1;
    bus_data_o = word;
    @(negedge clk_i);
    release_bus();
  endtask : write_word

  task automatic read_word(input logic [7:0] code);
    @(negedge clk_i);
    bus_cmd_o  = 1'b1;
    bus_rd_o   = 1'b1;
    bus_data_o = {8'h00, code};
    @(negedge clk_i);
    release_bus();
  endtask : read_word

endmodule : proc_bus_model

// file: tb/tb_top.sv
// Self-checking bench of the configuration register set
`timescale 1ns/1ps
`include "usb_cfg_regs_cfg.svh"

module tb_top;

  typedef struct {
    int          sel;
    logic [15:0] exp;
  } note_s;

  logic                          clk_i;
  logic                          rst_i;
  logic                          bus_cmd_i;
  logic                          bus_wr_i;
  logic                          bus_rd_i;
  logic [15:0]                   bus_data_i;
  logic [15:0]                   bus_data_o;
  logic                          usb_bus_reset_i;
  logic                          address_commit_i;
  logic                          resume_i;
  usb_cfg_regs_pkg::usb_events_s events_i;
  logic                          function_enable_o;
  logic [6:0]                    assigned_usb_address_o;
  logic                          dma_width_select_o;
  logic                          suspended_o;
  logic                          irq_o;
  logic                          internal_pullup_connect_o;
  logic                          osc_stop_o;
  logic                          clock_output_pin_o;
  note_s                         notes[$];
  int                            err_total;
  int                            check_count;
  logic                          rd_due;
  logic [31:0]                   rng;
  logic [15:0]                   measured;
  logic [15:0]                   rval;
  logic                          prev;
  string                         sig_names[7] = '{"bus_data_o", "address", "dma_width",
                                                  "suspended", "pullup", "osc_stop", "measured"};
  event                          snap;

  usb_device_config_registers #(.SUSP_CYCLES(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .bus_cmd_i(bus_cmd_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_data_i(bus_data_i), .bus_data_o(bus_data_o),
    .usb_bus_reset_i(usb_bus_reset_i), .address_commit_i(address_commit_i),
    .resume_i(resume_i), .events_i(events_i), .function_enable_o(function_enable_o),
    .assigned_usb_address_o(assigned_usb_address_o), .dma_width_select_o(dma_width_select_o),
    .suspended_o(suspended_o), .irq_o(irq_o),
    .internal_pullup_connect_o(internal_pullup_connect_o), .osc_stop_o(osc_stop_o),
    .clock_output_pin_o(clock_output_pin_o));

  proc_bus_model cpu (
    .clk_i(clk_i), .bus_cmd_o(bus_cmd_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i),
    .bus_data_o(bus_data_i));

  // ----------------------------------------
  // Clock, random source, observation
  // ----------------------------------------
  always #20 clk_i = ~clk_i;

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: return bus_data_o;
      1: return {8'h00, function_enable_o, assigned_usb_address_o};
      2: return {15'h0000, dma_width_select_o};
      3: return {15'h0000, suspended_o};
      4: return {15'h0000, internal_pullup_connect_o};
      5: return {15'h0000, osc_stop_o};
      default: return measured;
    endcase
  endfunction : obs

  // ----------------------------------------
  // Watcher: compares the oldest note with what the outputs show
  // ----------------------------------------
  task automatic check_one();
    note_s n;
    if (notes.size() == 0) begin
      err_total++;
      $display("CHECK FAILED queue expected a note seen none");
    end else begin
      n = notes.pop_front();
      check_count++;
      if (obs(n.sel) !== n.exp) begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", sig_names[n.sel], n.exp, obs(n.sel));
      end
    end
  endtask : check_one

  always @(posedge clk_i) begin
    rd_due <= bus_cmd_i && (bus_data_i[7:0] inside {`CMD_ADDR_RD, `CMD_MODE_RD, `CMD_HW_RD});
  end

  always @(negedge clk_i) begin
    if (rd_due === 1'b1) begin
      check_one();
    end
  end

  always @(snap) begin
    check_one();
  end

  // ----------------------------------------
  // Driver tasks
  // ----------------------------------------
  task automatic expect_now(input int sel, input logic [15:0] exp);
    notes.push_back('{sel, exp});
    -> snap;
    #1;
  endtask : expect_now

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    notes.push_back('{0, exp});
    cpu.read_word(code);
    @(negedge clk_i);
  endtask : rd

  task automatic count_toggles(input int cycles);
    measured = 16'h0000;
    prev = clock_output_pin_o;
    repeat (cycles) begin
      @(negedge clk_i);
      if (clock_output_pin_o !== prev) begin
        measured++;
      end
      prev = clock_output_pin_o;
    end
  endtask : count_toggles

  task automatic suspend_seq();
    cpu.write_word(`CMD_MODE_WR, 16'h0020);
    cpu.write_word(`CMD_MODE_WR, 16'h0000);
    @(negedge clk_i);
  endtask : suspend_seq

  task automatic stop_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    usb_bus_reset_i = 1'b0;
    address_commit_i = 1'b0;
    resume_i = 1'b0;
    events_i = '0;
    measured = 16'h0000;
    err_total = 0;
    check_count = 0;
    rng = 32'h00005378;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    rd(`CMD_MODE_RD, 16'h0000);
    rd(`CMD_HW_RD, 16'h2340);
    rng = xorshift(rng);
    rval = rng[15:0];
    cpu.write_word(`CMD_HW_WR, rval);
    rd(`CMD_HW_RD, rval);
    cpu.write_word(`CMD_HW_WR, 16'h2340);
    rng = xorshift(rng);
    cpu.write_word(`CMD_MODE_WR, {rng[7:0], 8'h8D});
    rd(`CMD_MODE_RD, 16'h008D);
    expect_now(2, 16'h0001);
    expect_now(4, 16'h0001);
    cpu.write_word(`CMD_HW_WR, 16'h6340);
    expect_now(4, 16'h0000);
    cpu.write_word(`CMD_HW_WR, 16'h2340);
    // Every event against every interrupt mode
    for (int m = 0; m < 16; m++) begin
      cpu.write_word(`CMD_MODE_WR, {12'h000, m[1], m[0], 2'b00});
      events_i = usb_cfg_regs_pkg::usb_events_s'(4'b1000 >> m[3:2]);
      @(negedge clk_i);
      events_i = '0;
      measured = {15'h0000, irq_o};
      @(negedge clk_i);
      measured[0] = measured[0] | irq_o;
      expect_now(6, {15'h0000, m[1] & (m[0] == m[3])});
    end
    cpu.write_word(`CMD_ADDR_WR, 16'h0085);
    rd(`CMD_ADDR_RD, 16'h0085);
    expect_now(1, 16'h0000);
    address_commit_i = 1'b1;
    @(negedge clk_i);
    address_commit_i = 1'b0;
    expect_now(1, 16'h0085);
    cpu.write_word(`CMD_MODE_WR, 16'h0000);
    @(negedge clk_i);
    expect_now(3, 16'h0000);
    expect_now(2, 16'h0000);
    suspend_seq();
    expect_now(3, 16'h0001);
    expect_now(5, 16'h0000);
    repeat (25) @(negedge clk_i);
    expect_now(5, 16'h0001);
    count_toggles(300);
    expect_now(6, 16'h0000);
    resume_i = 1'b1;
    @(negedge clk_i);
    resume_i = 1'b0;
    @(negedge clk_i);
    expect_now(3, 16'h0000);
    cpu.write_word(`CMD_HW_WR, 16'h0340);
    repeat (10) @(negedge clk_i);
    count_toggles(40);
    expect_now(6, 16'h0014);
    suspend_seq();
    repeat (25) @(negedge clk_i);
    count_toggles(2 * `SLOW_HALF);
    expect_now(6, 16'h0002);
    rng = xorshift(rng);
    cpu.write_word(`CMD_MODE_WR, {rng[7:0], 8'hFF});
    usb_bus_reset_i = 1'b1;
    @(negedge clk_i);
    usb_bus_reset_i = 1'b0;
    @(negedge clk_i);
    rd(`CMD_MODE_RD, 16'h008F);
    rd(`CMD_HW_RD, 16'h0340);
    rd(`CMD_ADDR_RD, 16'h0085);
    expect_now(1, 16'h0080);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    rd(`CMD_MODE_RD, 16'h0000);
    rd(`CMD_HW_RD, 16'h2340);
    expect_now(1, 16'h0000);
    stop_test();
  end

endmodule : tb_top
